// *** inc/standby_consts.svh ***
// Constants for the standby, watchdog and reset sequencer
`ifndef STANDBY_CONSTS_SVH
`define STANDBY_CONSTS_SVH
`define CLOCK_HZ 25000000
`define START_ADDRESS 16'h000C
`define OP_STOP 8'h6F
`define OP_HALT 8'h7F
`define OP_NOP 8'hFF
`define OP_WATCHDOG_IN_HALT 8'h4F
`define WATCHDOG_TIMEOUT_MS 12
`define WATCHDOG_CYCLES ((`WATCHDOG_TIMEOUT_MS * `CLOCK_HZ) / 1000)
`define OSC_SETTLE_CYCLES 1024
`define RESET_PULSE_CYCLES 16
`endif

// *** inc/standby_pkg.sv ***
// Types for the standby, watchdog and reset sequencer
package standby_pkg;
	typedef enum logic [1:0] {
		run_state,
		halt_state,
		stop_state,
		settle_state
	} power_state_e;
	typedef logic [15:0] address_t;
endpackage : standby_pkg

// *** hw/cycle_counter.sv ***
// Saturating cycle counter with clear, run enable and terminal flag
`timescale 1ns/1ns
module cycle_counter #(
	parameter int WIDTH = 20,
	parameter logic [WIDTH-1:0] LIMIT = '1
) (
	input wire logic i_clock,
	input wire logic i_rst,
	input wire logic i_clear,
	input wire logic i_run,
	output logic o_done
);
	logic [WIDTH-1:0] count;
	logic [WIDTH-1:0] next_count;
	logic next_done;

	if (WIDTH < 2 || LIMIT == '0) begin : check_params
		$error("cycle_counter: unusable width or limit");
	end

	always_comb begin
		next_count = count;
		if (i_clear) begin
			next_count = '0;
		end else if (i_run && count != LIMIT) begin
			next_count = count + 1'b1;
		end
		next_done = !i_clear && (next_count == LIMIT);
	end

	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			count <= '0;
			o_done <= 1'b0;
		end else begin
			count <= next_count;
			o_done <= next_done;
		end
	end
endmodule : cycle_counter

// *** hw/standby_watchdog_reset.sv ***
// Standby modes, watchdog supervision and reset entry for the CPU core
// Behaviour
// - After any reset, fetching starts at the fixed start address.
// - Two internal clock enables at crystal rate: timer clock and CPU clock.
// - HALT stops only the CPU clock; oscillator and timers keep running.
// - An enabled interrupt ends HALT; execution continues after HALT.
// - STOP halts the oscillator, stopping CPU and timer clocks.
// - STOP ends on reset or high recovery input; restart at start address.
// - Watchdog resets the device unless refreshed within its timeout.
// - Watchdog always enabled; cleared at power-on and by each refresh.
// - Watchdog-in-halt keeps watchdog counting in HALT; timeout resets.
// - Refresh also updates zero, sign and overflow flags.
// - Watchdog does not advance during STOP.
// - Low supply report drives global reset while it persists.
`timescale 1ns/1ns
`include "standby_consts.svh"
module standby_watchdog_reset #(
	parameter int WATCHDOG_CYCLES = `WATCHDOG_CYCLES,
	parameter int SETTLE_CYCLES = `OSC_SETTLE_CYCLES,
	parameter int RESET_CYCLES = `RESET_PULSE_CYCLES
) (
	input wire logic i_clock,
	input wire logic i_rst,
	input wire logic i_instr_valid,
	input wire logic [7:0] i_opcode,
	input wire logic i_watchdog_refresh,
	input wire logic i_irq_pending,
	input wire logic i_stop_recovery_input,
	input wire logic i_supply_sense_reset,
	output logic o_cpu_clock_en,
	output logic o_timer_interrupt_clock_en,
	output logic o_osc_enable,
	output logic o_core_reset,
	output standby_pkg::address_t o_restart_address,
	output logic o_flags_update,
	output logic o_flag_zero,
	output logic o_flag_sign,
	output logic o_flag_overflow,
	output logic o_watchdog_reset_seen,
	output standby_pkg::power_state_e o_power_state
);
	import standby_pkg::*;

	localparam int WD_WIDTH = $clog2(WATCHDOG_CYCLES + 1);
	localparam int ST_WIDTH = $clog2(SETTLE_CYCLES + 1);
	localparam int RS_WIDTH = $clog2(RESET_CYCLES + 1);

	if (WATCHDOG_CYCLES < 2) begin : check_watchdog_cycles
		$error("standby_watchdog_reset: watchdog count below two cycles");
	end
	if (SETTLE_CYCLES < 2) begin : check_settle_cycles
		$error("standby_watchdog_reset: settle count below two cycles");
	end
	if (RESET_CYCLES < 1) begin : check_reset_cycles
		$error("standby_watchdog_reset: reset pulse shorter than one cycle");
	end

	function automatic logic is_op(input logic valid, input logic [7:0] op,
		input logic [7:0] code);
		is_op = valid && (op == code);
	endfunction : is_op

	function automatic logic core_running(input power_state_e s,
		input logic [RS_WIDTH-1:0] count);
		core_running = (s == run_state) && (count == '0);
	endfunction : core_running

	power_state_e state;
	power_state_e next_state;
	logic wd_in_halt;
	logic next_wd_in_halt;
	logic [RS_WIDTH-1:0] reset_count;
	logic [RS_WIDTH-1:0] next_reset_count;
	logic wd_seen;
	logic next_wd_seen;
	logic wd_expired;
	logic wd_run;
	logic wd_clear;
	logic settle_done;
	logic settle_clear;
	logic reset_request;
	logic stop_cmd;
	logic halt_cmd;
	logic arm_cmd;
	logic core_live;

	// A core held in reset or without its clock executes nothing, so its opcodes are ignored
	assign core_live = core_running(state, reset_count);
	assign stop_cmd = core_live && is_op(i_instr_valid, i_opcode, `OP_STOP);
	assign halt_cmd = core_live && is_op(i_instr_valid, i_opcode, `OP_HALT);
	assign arm_cmd = core_live && is_op(i_instr_valid, i_opcode, `OP_WATCHDOG_IN_HALT);

	// Frozen in STOP; in HALT runs only when armed by the watchdog-in-halt opcode
	assign wd_run = (state == run_state) || (state == halt_state && wd_in_halt);
	assign wd_clear = i_watchdog_refresh || reset_request || state == settle_state;

	cycle_counter #(
		.WIDTH(WD_WIDTH),
		.LIMIT(WD_WIDTH'(WATCHDOG_CYCLES))
	) watchdog_counter (
		.i_clock(i_clock),
		.i_rst(i_rst),
		.i_clear(wd_clear),
		.i_run(wd_run),
		.o_done(wd_expired)
	);

	assign settle_clear = state != settle_state;

	cycle_counter #(
		.WIDTH(ST_WIDTH),
		.LIMIT(ST_WIDTH'(SETTLE_CYCLES))
	) settle_counter (
		.i_clock(i_clock),
		.i_rst(i_rst),
		.i_clear(settle_clear),
		.i_run(1'b1),
		.o_done(settle_done)
	);

	// Supply sense and watchdog expiry both force the core into reset
	assign reset_request = i_supply_sense_reset || (wd_expired && wd_run);

	always_comb begin
		next_state = state;
		next_wd_in_halt = wd_in_halt;
		next_reset_count = reset_count;
		next_wd_seen = wd_seen;
		if (reset_count != '0) begin
			next_reset_count = reset_count - 1'b1;
		end
		if (arm_cmd) begin
			next_wd_in_halt = 1'b1;
		end
		unique case (state)
			run_state: begin
				// The core keeps a NOP ahead of these so they arrive with a drained pipeline
				if (stop_cmd) begin
					next_state = stop_state;
				end else if (halt_cmd) begin
					next_state = halt_state;
				end
			end
			halt_state: begin
				if (i_irq_pending) begin
					next_state = run_state;
				end
			end
			stop_state: begin
				if (i_stop_recovery_input) begin
					next_state = settle_state;
				end
			end
			settle_state: begin
				if (settle_done) begin
					next_state = run_state;
					next_reset_count = RS_WIDTH'(RESET_CYCLES);
				end
			end
		endcase
		if (reset_request) begin
			// Reset also releases STOP; a stopped oscillator still needs to settle
			// Held in settle while reset persists, so the oscillator gets its full start-up
			if (state == stop_state || state == settle_state) begin
				next_state = settle_state;
			end else begin
				next_state = run_state;
			end
			next_reset_count = RS_WIDTH'(RESET_CYCLES);
			next_wd_in_halt = 1'b0;
			if (wd_expired && wd_run) begin
				next_wd_seen = 1'b1;
			end else if (i_supply_sense_reset) begin
				next_wd_seen = 1'b0;
			end
		end
	end

	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			state <= run_state;
			wd_in_halt <= 1'b0;
			reset_count <= RS_WIDTH'(RESET_CYCLES);
			wd_seen <= 1'b0;
		end else begin
			state <= next_state;
			wd_in_halt <= next_wd_in_halt;
			reset_count <= next_reset_count;
			wd_seen <= next_wd_seen;
		end
	end

	// Registered outputs taken from the next-state values, so they change with the state and the core sees clean enables
	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			o_cpu_clock_en <= 1'b0;
			o_timer_interrupt_clock_en <= 1'b0;
			o_osc_enable <= 1'b1;
			o_core_reset <= 1'b1;
			o_restart_address <= `START_ADDRESS;
			o_flags_update <= 1'b0;
			o_flag_zero <= 1'b0;
			o_flag_sign <= 1'b0;
			o_flag_overflow <= 1'b0;
			o_watchdog_reset_seen <= 1'b0;
			o_power_state <= run_state;
		end else begin
			o_cpu_clock_en <= core_running(next_state, next_reset_count);
			o_timer_interrupt_clock_en <= next_state == run_state
				|| next_state == halt_state;
			o_osc_enable <= next_state != stop_state;
			o_core_reset <= next_reset_count != '0 || next_state == settle_state
				|| i_supply_sense_reset;
			o_restart_address <= `START_ADDRESS;
			// Refresh leaves a non-zero, positive, no-overflow result
			o_flags_update <= i_watchdog_refresh;
			o_flag_zero <= 1'b0;
			o_flag_sign <= 1'b0;
			o_flag_overflow <= 1'b0;
			o_watchdog_reset_seen <= next_wd_seen;
			o_power_state <= next_state;
		end
	end
endmodule : standby_watchdog_reset

// *** dv/standby_watchdog_reset_props.sv ***
// Checker for the standby, watchdog and reset sequencer
`timescale 1ns/1ns
module standby_watchdog_reset_props
	import standby_pkg::*;
(
	input wire logic i_clock,
	input wire logic i_rst,
	input wire logic i_instr_valid,
	input wire logic [7:0] i_opcode,
	input wire logic i_watchdog_refresh,
	input wire logic i_irq_pending,
	input wire logic i_stop_recovery_input,
	input wire logic i_supply_sense_reset,
	input wire logic o_cpu_clock_en,
	input wire logic o_timer_interrupt_clock_en,
	input wire logic o_osc_enable,
	input wire logic o_core_reset,
	input wire standby_pkg::address_t o_restart_address,
	input wire logic o_flags_update,
	input wire logic o_watchdog_reset_seen,
	input wire standby_pkg::power_state_e o_power_state
);
	default clocking @(posedge i_clock); endclocking
	default disable iff (i_rst);
	addr_fixed_a: assert property (o_restart_address == 16'h000C)
		else $error("restart address wrong");
	halt_clocks_a: assert property (o_power_state == halt_state |->
		!o_cpu_clock_en && o_timer_interrupt_clock_en && o_osc_enable) else $error("halt clocks");
	halt_exit_a: assert property (o_power_state == halt_state && i_irq_pending |=>
		o_power_state == run_state) else $error("halt not left");
	stop_entry_a: assert property (i_instr_valid && i_opcode == 8'h6F && o_cpu_clock_en &&
		o_power_state == run_state |=> o_power_state == stop_state) else $error("no stop");
	stop_clocks_a: assert property (o_power_state == stop_state |->
		!o_osc_enable && !o_cpu_clock_en && !o_timer_interrupt_clock_en) else $error("stop clocks");
	stop_release_a: assert property (o_power_state == stop_state && i_stop_recovery_input
		|=> o_power_state == settle_state) else $error("stop not released");
	settle_hold_a: assert property (o_power_state == settle_state |-> o_core_reset)
		else $error("settle without reset");
	stop_frozen_a: assert property (o_power_state == stop_state |=>
		!$rose(o_watchdog_reset_seen)) else $error("watchdog fired in stop");
	refresh_flags_a: assert property (i_watchdog_refresh |=> o_flags_update)
		else $error("flags not updated");
	supply_reset_a: assert property (i_supply_sense_reset |=> o_core_reset)
		else $error("supply reset missing");
	cover property (o_power_state == halt_state ##1 o_power_state == run_state);
	cover property (o_power_state == stop_state ##1 o_power_state == settle_state);
	cover property ($rose(o_watchdog_reset_seen));
endmodule : standby_watchdog_reset_props
bind standby_watchdog_reset standby_watchdog_reset_props standby_watchdog_reset_props_i (
	.i_clock, .i_rst, .i_instr_valid, .i_opcode, .i_watchdog_refresh, .i_irq_pending,
	.i_stop_recovery_input, .i_supply_sense_reset, .o_cpu_clock_en, .o_timer_interrupt_clock_en,
	.o_osc_enable, .o_core_reset, .o_restart_address, .o_flags_update, .o_watchdog_reset_seen,
	.o_power_state);

// *** dv/cpu_core_model.sv ***
// Behavioural CPU core issuing standby instructions
`timescale 1ns/1ns
module cpu_core_model (
	input wire logic i_clock,
	input wire logic i_rst,
	input wire logic i_go,
	input wire logic [7:0] i_op,
	output logic o_instr_valid,
	output logic [7:0] o_opcode
);
	logic [1:0] step;
	always @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			step <= 2'h0;
			o_instr_valid <= 1'h0;
			o_opcode <= 8'h00;
		end else if (step == 2'h0 && i_go) begin
			o_instr_valid <= 1'h1;
			o_opcode <= 8'hFF;
			step <= 2'h1;
		end else if (step == 2'h1) begin
			o_opcode <= i_op;
			step <= 2'h2;
		end else begin
			// Toggling idle opcode so a stale value never passes for a command
			o_instr_valid <= 1'h0;
			o_opcode <= ~o_opcode;
			step <= 2'h0;
		end
	end
endmodule : cpu_core_model

// *** dv/standby_watchdog_reset_tb_top.sv ***
// Testbench for the standby, watchdog and reset sequencer
`timescale 1ns/1ns
module standby_watchdog_reset_tb_top;
	import standby_pkg::*;
	logic i_clock = 1'h0, i_rst = 1'h1, i_watchdog_refresh = 1'h0, i_irq_pending = 1'h0;
	logic i_stop_recovery_input = 1'h0, i_supply_sense_reset = 1'h0, go = 1'h0;
	logic i_instr_valid, o_cpu_clock_en, o_timer_interrupt_clock_en, o_osc_enable, o_core_reset;
	logic o_flags_update, o_flag_zero, o_flag_sign, o_flag_overflow, o_watchdog_reset_seen;
	logic [7:0] i_opcode, op = 8'h00;
	address_t o_restart_address;
	power_state_e o_power_state;
	int n_fail = 0, cmp_count = 0;
	always #20 i_clock = ~i_clock;
	standby_watchdog_reset #(.WATCHDOG_CYCLES(50), .SETTLE_CYCLES(8)) standby_watchdog_reset_i (
		.i_clock, .i_rst, .i_instr_valid, .i_opcode, .i_watchdog_refresh, .i_irq_pending,
		.i_stop_recovery_input, .i_supply_sense_reset, .o_cpu_clock_en, .o_timer_interrupt_clock_en,
		.o_osc_enable, .o_core_reset, .o_restart_address, .o_flags_update, .o_flag_zero,
		.o_flag_sign, .o_flag_overflow, .o_watchdog_reset_seen, .o_power_state);
	cpu_core_model cpu_core_model_i (.i_clock, .i_rst, .i_go(go), .i_op(op),
		.o_instr_valid(i_instr_valid), .o_opcode(i_opcode));
	task chk(input logic [15:0] got, input logic [15:0] exp);
		cmp_count++;
		if (got !== exp) begin
			n_fail++;
			$display("ERROR t=%0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	task cyc(input int n);
		repeat (n) @(posedge i_clock);
		#2;
	endtask : cyc
	task issue(input logic [7:0] c);
		op = c;
		go = 1'h1;
		cyc(1);
		go = 1'h0;
		cyc(3);
	endtask : issue
	task refresh;
		i_watchdog_refresh = 1'h1;
		cyc(1);
		i_watchdog_refresh = 1'h0;
	endtask : refresh
	task wait_run;
		int k;
		k = 0;
		while (o_cpu_clock_en !== 1'h1 && k < 100) begin
			cyc(1);
			k++;
		end
		chk(16'({o_cpu_clock_en, o_core_reset, o_power_state}), 16'h0008);
	endtask : wait_run
	task t_halt;
		refresh;
		issue(8'h7F);
		chk(16'({o_power_state, o_cpu_clock_en, o_timer_interrupt_clock_en, o_osc_enable}), 16'h000B);
		cyc(60);
		chk(16'(o_core_reset), 16'h0000);
		i_irq_pending = 1'h1;
		cyc(1);
		i_irq_pending = 1'h0;
		chk(16'({o_power_state, o_cpu_clock_en}), 16'h0001);
	endtask : t_halt
	task t_stop;
		refresh;
		issue(8'h6F);
		chk(16'({o_power_state, o_cpu_clock_en, o_timer_interrupt_clock_en, o_osc_enable}), 16'h0010);
		cyc(60);
		chk(16'({o_core_reset, o_watchdog_reset_seen}), 16'h0000);
		i_stop_recovery_input = 1'h1;
		cyc(1);
		i_stop_recovery_input = 1'h0;
		chk(16'({o_power_state, o_core_reset, o_cpu_clock_en}), 16'h000E);
		cyc(20);
		chk(16'(o_core_reset), 16'h0001);
		wait_run;
	endtask : t_stop
	task t_wdog;
		refresh;
		chk(16'({o_flags_update, o_flag_zero, o_flag_sign, o_flag_overflow}), 16'h0008);
		repeat (3) begin
			cyc(40);
			refresh;
		end
		cyc(45);
		chk(16'(o_core_reset), 16'h0000);
		cyc(7);
		chk(16'({o_core_reset, o_watchdog_reset_seen}), 16'h0003);
		wait_run;
	endtask : t_wdog
	task t_supply;
		refresh;
		i_supply_sense_reset = 1'h1;
		cyc(1);
		chk(16'(o_core_reset), 16'h0001);
		cyc(30);
		chk(16'(o_core_reset), 16'h0001);
		i_supply_sense_reset = 1'h0;
		wait_run;
		chk(16'(o_watchdog_reset_seen), 16'h0000);
	endtask : t_supply
	task t_wdh;
		refresh;
		issue(8'h4F);
		issue(8'h7F);
		chk(16'(o_power_state), 16'h0001);
		cyc(40);
		chk(16'(o_core_reset), 16'h0000);
		cyc(10);
		chk(16'({o_core_reset, o_watchdog_reset_seen}), 16'h0003);
		wait_run;
	endtask : t_wdh
	task t_stop_supply;
		refresh;
		issue(8'h6F);
		i_supply_sense_reset = 1'h1;
		cyc(3);
		chk(16'({o_power_state, o_osc_enable, o_core_reset}), 16'h000F);
		i_supply_sense_reset = 1'h0;
		wait_run;
	endtask : t_stop_supply
	task give_verdict;
		$display("comparisons %0d mismatches %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : give_verdict
	initial begin
		cyc(16);
		i_rst = 1'h0;
		wait_run;
		chk(o_restart_address, 16'h000C);
		chk(16'({o_timer_interrupt_clock_en, o_osc_enable, o_watchdog_reset_seen}), 16'h0006);
		t_halt;
		t_stop;
		t_wdog;
		t_supply;
		t_stop_supply;
		t_wdh;
		give_verdict;
	end
	// Whole sequence needs under 1000 cycles; this limit leaves ample margin
	initial begin
		#200000;
		n_fail++;
		give_verdict;
	end
endmodule : standby_watchdog_reset_tb_top
